// ==== core/cpc_top.sv ====
// capture channel, pulse compare channel and their two 16-bit time bases
// assumes a synchronous register port master and an asynchronous capture pin
//
// Overview of operation
// - idle-stop bit halts capture in idle
// - time-base bit one captures first timer
// - interrupt after one to four captures
// - overflow flag read-only, hardware cleared
// - not-empty flag while unread captures remain
// - mode 111: rising-edge wake interrupt only
// - modes 000 and 110 disable capture
// - modes 101/100 capture every 16th/4th rise
// - modes 011/010 capture every rise/fall
// - mode 001 both edges, every capture interrupts
// - compare mode 100: output low, one pulse
// - primary match drives output high
// - single: secondary match ends, then stays low
// - secondary match sets flag, enable gates request
// - compare mode 101: output low, repeat pulses
// - time base wraps to zero at period
// - continuous: flag on every secondary match that ends a pulse
// - compare select one picks second timer
// - compare mode 000 disables channel
`timescale 1ns/1ns
`include "cpc_map.svh"

module cpc_top (
    input  wire logic              i_ref_clk,
    input  wire logic              i_rst_b,
    input  wire logic [3:0]        i_addr,
    input  wire cpc_pkg::cpc_word_t i_wr_data,
    input  wire logic              i_wr_stb,
    input  wire logic              i_rd_stb,
    output cpc_pkg::cpc_word_t     o_rd_data,
    input  wire logic              i_capture_pin,
    input  wire logic              i_cpu_idle,
    input  wire logic              i_cpu_sleep,
    output logic                   o_capture_irq,
    output logic                   o_compare_output_pin,
    output logic                   o_compare_irq
);
    import cpc_pkg::*;

    // software-visible configuration and time bases
    logic           capture_idle_stop_reg, capture_idle_stop_next;
    logic           capture_timebase_select_reg, capture_timebase_select_next;
    logic [1:0]     captures_per_interrupt_reg, captures_per_interrupt_next;
    cpc_cap_mode_t  capture_mode_field_reg, capture_mode_field_next;
    logic           compare_timebase_select_reg, compare_timebase_select_next;
    logic [2:0]     compare_mode_field_reg, compare_mode_field_next;
    logic           compare_interrupt_enable_reg, compare_interrupt_enable_next;
    cpc_word_t      primary_compare_value_reg, primary_compare_value_next;
    cpc_word_t      secondary_compare_value_reg, secondary_compare_value_next;
    logic           run1_reg, run1_next;
    logic           run2_reg, run2_next;
    cpc_word_t      period1_reg, period1_next;
    cpc_word_t      period2_reg, period2_next;
    cpc_word_t      first_timer_count_reg, first_timer_count_next;
    cpc_word_t      second_timer_count_reg, second_timer_count_next;
    cpc_word_t      rd_data_reg, rd_data_next;
    logic           cmp_mode_wr;

    // capture path state
    logic [2:0]     pin_sync_reg;
    logic [2:0]     pin_sync_next;
    logic           pin_level_reg, pin_level_next;
    logic [3:0]     prescale_reg, prescale_next;
    logic [1:0]     irq_cnt_reg, irq_cnt_next;
    cpc_word_t      fifo_mem_reg [4];
    cpc_word_t      fifo_mem_next [4];
    logic [1:0]     wr_ptr_reg, wr_ptr_next;
    logic [1:0]     rd_ptr_reg, rd_ptr_next;
    logic [2:0]     fill_reg, fill_next;
    logic           capture_overflow_flag_reg, capture_overflow_flag_next;
    logic           cap_irq_reg, cap_irq_next;

    // compare path state
    cpc_cmp_state_t cmp_state_reg, cmp_state_next;
    logic           cmp_out_reg, cmp_out_next;
    logic           compare_interrupt_flag_reg, compare_interrupt_flag_next;

    logic           pin_stable;
    logic           rise;
    logic           fall;
    logic           cap_run;
    logic           cap_event;
    logic           pop;
    logic           push;
    logic           capture_buffer_not_empty;
    cpc_word_t      cap_stamp;
    cpc_word_t      cmp_count;

    assign pin_stable = (pin_sync_reg[1] == pin_sync_reg[2]);
    assign rise = pin_stable && pin_sync_reg[2] && !pin_level_reg;
    assign fall = pin_stable && !pin_sync_reg[2] && pin_level_reg;
    assign capture_buffer_not_empty = (fill_reg != 3'h0);
    assign pop = i_rd_stb && (i_addr == `CPC_OFF_IC_BUF) && capture_buffer_not_empty;
    assign cap_stamp = capture_timebase_select_reg ? first_timer_count_reg
                                                   : second_timer_count_reg;
    assign cmp_count = compare_timebase_select_reg ? second_timer_count_reg
                                                   : first_timer_count_reg;
    assign cmp_mode_wr = i_wr_stb && (i_addr == `CPC_OFF_OC_CTRL);

    // register port and time bases
    always_comb begin
        capture_idle_stop_next        = capture_idle_stop_reg;
        capture_timebase_select_next  = capture_timebase_select_reg;
        captures_per_interrupt_next   = captures_per_interrupt_reg;
        capture_mode_field_next       = capture_mode_field_reg;
        compare_timebase_select_next  = compare_timebase_select_reg;
        compare_mode_field_next       = compare_mode_field_reg;
        compare_interrupt_enable_next = compare_interrupt_enable_reg;
        primary_compare_value_next    = primary_compare_value_reg;
        secondary_compare_value_next  = secondary_compare_value_reg;
        run1_next                     = run1_reg;
        run2_next                     = run2_reg;
        period1_next                  = period1_reg;
        period2_next                  = period2_reg;
        rd_data_next                  = `CPC_RST_WORD;
        first_timer_count_next = first_timer_count_reg;
        if (run1_reg) begin
            first_timer_count_next = (first_timer_count_reg == period1_reg) ? 16'h0000
                                     : first_timer_count_reg + 16'h0001;
        end
        second_timer_count_next = second_timer_count_reg;
        if (run2_reg) begin
            second_timer_count_next = (second_timer_count_reg == period2_reg) ? 16'h0000
                                      : second_timer_count_reg + 16'h0001;
        end
        if (i_wr_stb) begin
            if (i_addr == `CPC_OFF_IC_CTRL) begin
                capture_idle_stop_next       = i_wr_data[`CPC_IC_IDLE_STOP_BIT];
                capture_timebase_select_next = i_wr_data[`CPC_IC_TSEL_BIT];
                captures_per_interrupt_next  = i_wr_data[`CPC_IC_ICI_HI:`CPC_IC_ICI_LO];
                capture_mode_field_next =
                    cpc_cap_mode_t'(i_wr_data[`CPC_IC_MODE_HI:`CPC_IC_MODE_LO]);
            end else if (i_addr == `CPC_OFF_OC_CTRL) begin
                compare_interrupt_enable_next = i_wr_data[`CPC_OC_IE_BIT];
                compare_timebase_select_next  = i_wr_data[`CPC_OC_TSEL_BIT];
                compare_mode_field_next = i_wr_data[`CPC_OC_MODE_HI:`CPC_OC_MODE_LO];
            end else if (i_addr == `CPC_OFF_OC_PRIMARY) begin
                primary_compare_value_next = i_wr_data;
            end else if (i_addr == `CPC_OFF_OC_SECONDARY) begin
                secondary_compare_value_next = i_wr_data;
            end else if (i_addr == `CPC_OFF_TMR_CTRL) begin
                run1_next = i_wr_data[`CPC_TMR_RUN1_BIT];
                run2_next = i_wr_data[`CPC_TMR_RUN2_BIT];
            end else if (i_addr == `CPC_OFF_PERIOD1) begin
                period1_next = i_wr_data;
            end else if (i_addr == `CPC_OFF_PERIOD2) begin
                period2_next = i_wr_data;
            end else if (i_addr == `CPC_OFF_COUNT1) begin
                first_timer_count_next = i_wr_data;
            end else if (i_addr == `CPC_OFF_COUNT2) begin
                second_timer_count_next = i_wr_data;
            end
        end
        if (i_rd_stb) begin
            if (i_addr == `CPC_OFF_IC_CTRL) begin
                rd_data_next[`CPC_IC_IDLE_STOP_BIT]           = capture_idle_stop_reg;
                rd_data_next[`CPC_IC_TSEL_BIT]                = capture_timebase_select_reg;
                rd_data_next[`CPC_IC_ICI_HI:`CPC_IC_ICI_LO]   = captures_per_interrupt_reg;
                rd_data_next[`CPC_IC_OVF_BIT]                 = capture_overflow_flag_reg;
                rd_data_next[`CPC_IC_BNE_BIT]                 = capture_buffer_not_empty;
                rd_data_next[`CPC_IC_MODE_HI:`CPC_IC_MODE_LO] = capture_mode_field_reg;
            end else if (i_addr == `CPC_OFF_IC_BUF) begin
                rd_data_next = capture_buffer_not_empty ? fifo_mem_reg[rd_ptr_reg]
                                                        : `CPC_RST_WORD;
            end else if (i_addr == `CPC_OFF_OC_CTRL) begin
                rd_data_next[`CPC_OC_IE_BIT]   = compare_interrupt_enable_reg;
                rd_data_next[`CPC_OC_FLAG_BIT] = compare_interrupt_flag_reg;
                rd_data_next[`CPC_OC_TSEL_BIT] = compare_timebase_select_reg;
                rd_data_next[`CPC_OC_MODE_HI:`CPC_OC_MODE_LO] = compare_mode_field_reg;
            end else if (i_addr == `CPC_OFF_OC_PRIMARY) begin
                rd_data_next = primary_compare_value_reg;
            end else if (i_addr == `CPC_OFF_OC_SECONDARY) begin
                rd_data_next = secondary_compare_value_reg;
            end else if (i_addr == `CPC_OFF_TMR_CTRL) begin
                rd_data_next[`CPC_TMR_RUN1_BIT] = run1_reg;
                rd_data_next[`CPC_TMR_RUN2_BIT] = run2_reg;
            end else if (i_addr == `CPC_OFF_PERIOD1) begin
                rd_data_next = period1_reg;
            end else if (i_addr == `CPC_OFF_PERIOD2) begin
                rd_data_next = period2_reg;
            end else if (i_addr == `CPC_OFF_COUNT1) begin
                rd_data_next = first_timer_count_reg;
            end else if (i_addr == `CPC_OFF_COUNT2) begin
                rd_data_next = second_timer_count_reg;
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            capture_idle_stop_reg        <= 1'b0;
            capture_timebase_select_reg  <= 1'b0;
            captures_per_interrupt_reg   <= 2'h0;
            capture_mode_field_reg       <= CPC_CAP_OFF;
            compare_timebase_select_reg  <= 1'b0;
            compare_mode_field_reg       <= 3'h0;
            compare_interrupt_enable_reg <= 1'b0;
            primary_compare_value_reg    <= `CPC_RST_WORD;
            secondary_compare_value_reg  <= `CPC_RST_WORD;
            run1_reg                     <= 1'b0;
            run2_reg                     <= 1'b0;
            period1_reg                  <= `CPC_RST_PERIOD;
            period2_reg                  <= `CPC_RST_PERIOD;
            first_timer_count_reg        <= `CPC_RST_WORD;
            second_timer_count_reg       <= `CPC_RST_WORD;
            rd_data_reg                  <= `CPC_RST_WORD;
        end else begin
            capture_idle_stop_reg        <= capture_idle_stop_next;
            capture_timebase_select_reg  <= capture_timebase_select_next;
            captures_per_interrupt_reg   <= captures_per_interrupt_next;
            capture_mode_field_reg       <= capture_mode_field_next;
            compare_timebase_select_reg  <= compare_timebase_select_next;
            compare_mode_field_reg       <= compare_mode_field_next;
            compare_interrupt_enable_reg <= compare_interrupt_enable_next;
            primary_compare_value_reg    <= primary_compare_value_next;
            secondary_compare_value_reg  <= secondary_compare_value_next;
            run1_reg                     <= run1_next;
            run2_reg                     <= run2_next;
            period1_reg                  <= period1_next;
            period2_reg                  <= period2_next;
            first_timer_count_reg        <= first_timer_count_next;
            second_timer_count_reg       <= second_timer_count_next;
            rd_data_reg                  <= rd_data_next;
        end
    end

    // capture channel
    always_comb begin
        pin_sync_next  = {pin_sync_reg[1:0], i_capture_pin};
        // a change counts once the last two stages agree, which rejects one-cycle glitches
        pin_level_next = pin_stable ? pin_sync_reg[2] : pin_level_reg;
        prescale_next  = prescale_reg;
        irq_cnt_next   = irq_cnt_reg;
        cap_irq_next   = 1'b0;
        cap_event      = 1'b0;
        cap_run = !(i_cpu_idle && capture_idle_stop_reg);
        case (capture_mode_field_reg)
            CPC_CAP_ANY:    cap_event = rise || fall;
            CPC_CAP_FALL:   cap_event = fall;
            CPC_CAP_RISE:   cap_event = rise;
            CPC_CAP_RISE4:  cap_event = rise && (prescale_reg == `CPC_PRE4_LAST);
            CPC_CAP_RISE16: cap_event = rise && (prescale_reg == `CPC_PRE16_LAST);
            default:        cap_event = 1'b0;
        endcase
        cap_event = cap_event && cap_run;
        if (cap_run && rise && ((capture_mode_field_reg == CPC_CAP_RISE4) ||
                                (capture_mode_field_reg == CPC_CAP_RISE16))) begin
            prescale_next = (capture_mode_field_reg == CPC_CAP_RISE4 &&
                             prescale_reg == `CPC_PRE4_LAST) ? 4'h0 : prescale_reg + 4'h1;
        end
        if (cap_event) begin
            if (capture_mode_field_reg == CPC_CAP_ANY) begin
                cap_irq_next = 1'b1;
            end else if (irq_cnt_reg == captures_per_interrupt_reg) begin
                cap_irq_next = 1'b1;
                irq_cnt_next = 2'h0;
            end else begin
                irq_cnt_next = irq_cnt_reg + 2'h1;
            end
        end
        if (capture_mode_field_reg == CPC_CAP_WAKE) begin
            cap_irq_next = rise && (i_cpu_sleep || i_cpu_idle);
        end
        push = cap_event && ((fill_reg != `CPC_FIFO_DEPTH) || pop);
        fifo_mem_next = fifo_mem_reg;
        wr_ptr_next   = wr_ptr_reg;
        rd_ptr_next   = rd_ptr_reg;
        fill_next     = fill_reg;
        capture_overflow_flag_next = capture_overflow_flag_reg;
        if (push) begin
            fifo_mem_next[wr_ptr_reg] = cap_stamp;
            wr_ptr_next = wr_ptr_reg + 2'h1;
        end
        if (pop) begin
            rd_ptr_next = rd_ptr_reg + 2'h1;
        end
        fill_next = fill_reg + {2'h0, push} - {2'h0, pop};
        if ((capture_mode_field_reg == CPC_CAP_OFF) ||
            (capture_mode_field_reg == CPC_CAP_UNUSED)) begin
            prescale_next = 4'h0;
            irq_cnt_next  = 2'h0;
            wr_ptr_next   = 2'h0;
            rd_ptr_next   = 2'h0;
            fill_next     = 3'h0;
            capture_overflow_flag_next = 1'b0;
        end
        if (cap_event && (fill_reg == `CPC_FIFO_DEPTH) && !pop) begin
            capture_overflow_flag_next = 1'b1;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            pin_sync_reg  <= 3'h0;
            pin_level_reg <= 1'b0;
            prescale_reg  <= 4'h0;
            irq_cnt_reg   <= 2'h0;
            fifo_mem_reg  <= '{default: `CPC_RST_WORD};
            wr_ptr_reg    <= 2'h0;
            rd_ptr_reg    <= 2'h0;
            fill_reg      <= 3'h0;
            capture_overflow_flag_reg <= 1'b0;
            cap_irq_reg   <= 1'b0;
        end else begin
            pin_sync_reg  <= pin_sync_next;
            pin_level_reg <= pin_level_next;
            prescale_reg  <= prescale_next;
            irq_cnt_reg   <= irq_cnt_next;
            fifo_mem_reg  <= fifo_mem_next;
            wr_ptr_reg    <= wr_ptr_next;
            rd_ptr_reg    <= rd_ptr_next;
            fill_reg      <= fill_next;
            capture_overflow_flag_reg <= capture_overflow_flag_next;
            cap_irq_reg   <= cap_irq_next;
        end
    end

    // compare channel
    always_comb begin
        cmp_state_next = cmp_state_reg;
        cmp_out_next   = cmp_out_reg;
        compare_interrupt_flag_next = compare_interrupt_flag_reg;
        // flag clears by writing one; a same-cycle match still sets it below
        if (cmp_mode_wr && i_wr_data[`CPC_OC_FLAG_BIT]) begin
            compare_interrupt_flag_next = 1'b0;
        end
        case (cmp_state_reg)
            CPC_ST_ARM: begin
                if (cmp_count == primary_compare_value_reg) begin
                    cmp_out_next   = 1'b1;
                    cmp_state_next = CPC_ST_HIGH;
                end
            end
            CPC_ST_HIGH: begin
                if (cmp_count == secondary_compare_value_reg) begin
                    cmp_out_next = 1'b0;
                    compare_interrupt_flag_next = 1'b1;
                    cmp_state_next = (compare_mode_field_reg == CPC_CMP_CONT) ? CPC_ST_ARM
                                                                              : CPC_ST_DONE;
                end
            end
            default: begin
                cmp_state_next = cmp_state_reg;
            end
        endcase
        if (cmp_mode_wr) begin
            cmp_out_next = 1'b0;
            if ((i_wr_data[`CPC_OC_MODE_HI:`CPC_OC_MODE_LO] == CPC_CMP_SINGLE) ||
                (i_wr_data[`CPC_OC_MODE_HI:`CPC_OC_MODE_LO] == CPC_CMP_CONT)) begin
                cmp_state_next = CPC_ST_ARM;
            end else begin
                cmp_state_next = CPC_ST_IDLE;
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cmp_state_reg <= CPC_ST_IDLE;
            cmp_out_reg   <= 1'b0;
            compare_interrupt_flag_reg <= 1'b0;
        end else begin
            cmp_state_reg <= cmp_state_next;
            cmp_out_reg   <= cmp_out_next;
            compare_interrupt_flag_reg <= compare_interrupt_flag_next;
        end
    end

    assign o_rd_data            = rd_data_reg;
    assign o_capture_irq        = cap_irq_reg;
    assign o_compare_output_pin = cmp_out_reg;
    assign o_compare_irq = compare_interrupt_flag_reg && compare_interrupt_enable_reg;

endmodule // cpc_top

// ==== core/cpc_map.svh ====
// register map, field positions, reset values and counts for the capture/compare block
// assumes a 16-bit register port with 4-bit word addresses
`ifndef CPC_MAP_SVH
`define CPC_MAP_SVH

`define CPC_OFF_IC_CTRL      4'h0
`define CPC_OFF_IC_BUF       4'h1
`define CPC_OFF_OC_CTRL      4'h2
`define CPC_OFF_OC_PRIMARY   4'h3
`define CPC_OFF_OC_SECONDARY 4'h4
`define CPC_OFF_TMR_CTRL     4'h5
`define CPC_OFF_PERIOD1      4'h6
`define CPC_OFF_PERIOD2      4'h7
`define CPC_OFF_COUNT1       4'h8
`define CPC_OFF_COUNT2       4'h9

`define CPC_IC_IDLE_STOP_BIT 13
`define CPC_IC_TSEL_BIT      7
`define CPC_IC_ICI_HI        6
`define CPC_IC_ICI_LO        5
`define CPC_IC_OVF_BIT       4
`define CPC_IC_BNE_BIT       3
`define CPC_IC_MODE_HI       2
`define CPC_IC_MODE_LO       0

`define CPC_OC_IE_BIT        9
`define CPC_OC_FLAG_BIT      8
`define CPC_OC_TSEL_BIT      3
`define CPC_OC_MODE_HI       2
`define CPC_OC_MODE_LO       0

`define CPC_TMR_RUN1_BIT     0
`define CPC_TMR_RUN2_BIT     1

`define CPC_RST_WORD         16'h0000
`define CPC_RST_PERIOD       16'hFFFF

`define CPC_FIFO_DEPTH       3'h4
`define CPC_PRE4_LAST        4'h3
`define CPC_PRE16_LAST       4'hF

`endif

// ==== core/cpc_pkg.sv ====
// types shared by the capture/compare block
// constants live in cpc_map.svh
package cpc_pkg;
    typedef enum logic [2:0] {
        CPC_CAP_OFF   = 3'h0,
        CPC_CAP_ANY   = 3'h1,
        CPC_CAP_FALL  = 3'h2,
        CPC_CAP_RISE  = 3'h3,
        CPC_CAP_RISE4 = 3'h4,
        CPC_CAP_RISE16 = 3'h5,
        CPC_CAP_UNUSED = 3'h6,
        CPC_CAP_WAKE  = 3'h7
    } cpc_cap_mode_t;

    typedef enum logic [2:0] {
        CPC_CMP_OFF    = 3'h0,
        CPC_CMP_SINGLE = 3'h4,
        CPC_CMP_CONT   = 3'h5
    } cpc_cmp_mode_t;

    typedef enum logic [3:0] {
        CPC_ST_IDLE = 4'b0001,
        CPC_ST_ARM  = 4'b0010,
        CPC_ST_HIGH = 4'b0100,
        CPC_ST_DONE = 4'b1000
    } cpc_cmp_state_t;

    typedef logic [15:0] cpc_word_t;
endpackage

// ==== verification/cpc_pin_model.sv ====
// pin-side model: capture edge source and pulse pin watcher
// assumes the bench runs one burst at a time
`timescale 1ns/1ns
module cpc_pin_model (
    input  wire logic   i_ref_clk,
    input  wire logic   i_pulse_pin,
    output logic        o_edge,
    output logic [15:0] o_rises,
    output logic [15:0] o_high
);
    logic prev = 1'b0;
    initial {o_edge, o_rises, o_high} = '0;
    always @(posedge i_ref_clk) begin
        prev <= i_pulse_pin;
        o_rises <= o_rises + 16'(i_pulse_pin && !prev);
        o_high <= o_high + 16'(i_pulse_pin);
    end
    // four cycles per level, so the synchroniser never filters an edge
    task automatic send(input int n);
        repeat (n) begin
            repeat (4) @(posedge i_ref_clk);
            o_edge <= 1'b1;
            repeat (4) @(posedge i_ref_clk);
            o_edge <= 1'b0;
        end
        repeat (8) @(posedge i_ref_clk);
    endtask
endmodule // cpc_pin_model

// ==== verification/cpc_top_properties.sv ====
// port checker for the capture/compare block
// assumes control writes land at the edge that takes them
`timescale 1ns/1ns
module cpc_checker (
    input wire logic               i_ref_clk,
    input wire logic               i_rst_b,
    input wire logic [3:0]         i_addr,
    input wire cpc_pkg::cpc_word_t i_wr_data,
    input wire logic               i_wr_stb,
    input wire logic               i_cpu_idle,
    input wire logic               i_cpu_sleep,
    input wire logic               o_capture_irq,
    input wire logic               o_compare_output_pin,
    input wire logic               o_compare_irq
);
    import cpc_pkg::*;
    cpc_word_t ic_reg, ic_next, oc_reg, oc_next;
    always_comb begin
        ic_next = ic_reg;
        oc_next = oc_reg;
        if (i_wr_stb && i_addr == 4'h0) ic_next = i_wr_data;
        if (i_wr_stb && i_addr == 4'h2) oc_next = i_wr_data;
    end
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ic_reg <= 16'h0000;
            oc_reg <= 16'h0000;
        end else begin
            ic_reg <= ic_next;
            oc_reg <= oc_next;
        end
    end
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_rst_b);
    irq_one_cycle_a: assert property (o_capture_irq |=> !o_capture_irq)
        else $error("capture irq too wide");
    cap_off_quiet_a: assert property (ic_reg[2:0] inside {3'h0, 3'h6} &&
        $past(ic_reg[2:0]) == ic_reg[2:0] |-> !o_capture_irq) else $error("irq while off");
    wake_only_a: assert property (ic_reg[2:0] == 3'h7 && $past(ic_reg[2:0]) == 3'h7 &&
        !$past(i_cpu_sleep) && !$past(i_cpu_idle) |-> !o_capture_irq) else $error("wake irq");
    idle_halt_a: assert property (ic_reg[13] && $past(ic_reg[13]) && $past(i_cpu_idle) &&
        ic_reg[2:0] != 3'h7 && $past(ic_reg[2:0]) != 3'h7 |-> !o_capture_irq)
        else $error("irq in idle stop");
    arm_low_a: assert property (i_wr_stb && i_addr == 4'h2 |=> !o_compare_output_pin)
        else $error("pin not low after arm");
    cmp_off_low_a: assert property (oc_reg[2:1] != 2'b10 |-> !o_compare_output_pin)
        else $error("pin high while off");
    irq_gate_a: assert property (!oc_reg[9] |-> !o_compare_irq)
        else $error("compare irq not enabled");
    irq_clear_a: assert property ($fell(o_compare_irq) |-> $past(i_wr_stb) &&
        $past(i_addr) == 4'h2) else $error("compare irq dropped");
    cover property ($fell(o_compare_output_pin));
    cover property (o_capture_irq && ic_reg[2:0] == 3'h5);
    cover property (o_compare_irq);
endmodule // cpc_checker

bind cpc_top cpc_checker i_cpc_checker (.i_ref_clk, .i_rst_b, .i_addr, .i_wr_data, .i_wr_stb,
    .i_cpu_idle, .i_cpu_sleep, .o_capture_irq, .o_compare_output_pin, .o_compare_irq);

// ==== verification/tb_capture_and_pulse_compare.sv ====
// self-checking bench for the capture/compare block
// assumes the pin model and the bound checker
`timescale 1ns/1ns
module tb_capture_and_pulse_compare;
    import cpc_pkg::*;
    logic      i_ref_clk = 0, i_rst_b = 0, i_wr_stb = 0, i_rd_stb = 0;
    logic      i_cpu_idle = 0, i_cpu_sleep = 0, cap_pin, o_capture_irq, pin, o_compare_irq;
    logic [3:0] i_addr = 4'h0;
    cpc_word_t i_wr_data = 16'h0000, o_rd_data, v;
    int        fails = 0, tests_run = 0, n_irq = 0, cyc = 0, base = 0;
    // control word, sleep, idle, expected interrupts for sixteen input pulses
    logic [31:0] rows [14] = '{32'h0001_0020, 32'h0002_0010, 32'h0003_0010, 32'h0004_0004,
        32'h0005_0001, 32'h0000_0000, 32'h0006_0000, 32'h0007_8010, 32'h0007_0000,
        32'h0063_0004, 32'h0043_0005, 32'h0061_0020, 32'h2003_4000, 32'h0003_4010};
    cpc_top i_cpc_top (.i_ref_clk, .i_rst_b, .i_addr, .i_wr_data, .i_wr_stb, .i_rd_stb,
        .o_rd_data, .i_capture_pin(cap_pin), .i_cpu_idle, .i_cpu_sleep, .o_capture_irq,
        .o_compare_output_pin(pin), .o_compare_irq);
    cpc_pin_model i_cpc_pin_model (.i_ref_clk, .i_pulse_pin(pin), .o_edge(cap_pin),
        .o_rises(), .o_high());
    initial forever #25 i_ref_clk = ~i_ref_clk;
    always @(posedge i_ref_clk) begin
        n_irq <= n_irq + int'(o_capture_irq);
        cyc <= cyc + 1;
        if (cyc == 10000) begin
            fails++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input cpc_word_t s, input cpc_word_t e);
        tests_run++;
        if (s !== e) begin
            fails++;
            $display("wrong value at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [3:0] a, input cpc_word_t d);
        @(posedge i_ref_clk);
        {i_wr_stb, i_addr, i_wr_data} <= {1'b1, a, d};
        @(posedge i_ref_clk);
        i_wr_stb <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output cpc_word_t d);
        @(posedge i_ref_clk);
        {i_rd_stb, i_addr} <= {1'b1, a};
        @(posedge i_ref_clk);
        i_rd_stb <= 1'b0;
        @(negedge i_ref_clk);
        d = o_rd_data;
    endtask
    task automatic win(input int n, input cpc_word_t r, input cpc_word_t h);
        cpc_word_t r0, h0;
        @(negedge i_ref_clk);
        {r0, h0} = {i_cpc_pin_model.o_rises, i_cpc_pin_model.o_high};
        repeat (n) @(negedge i_ref_clk);
        chk(i_cpc_pin_model.o_rises - r0, r);
        chk(i_cpc_pin_model.o_high - h0, h);
    endtask
    initial begin
        repeat (12) @(posedge i_ref_clk);
        i_rst_b <= 1'b1;
        foreach (rows[k]) begin
            base = n_irq;
            wr(4'h0, 16'h0000);
            {i_cpu_sleep, i_cpu_idle} <= rows[k][15:14];
            wr(4'h0, rows[k][31:16]);
            chk(16'(n_irq - base), 16'h0000);
            i_cpc_pin_model.send(16);
            chk(16'(n_irq - base), {2'b00, rows[k][13:0]});
            $display("test row %0d done", k);
        end
        {i_cpu_sleep, i_cpu_idle} <= 2'b00;
        wr(4'h0, 16'h0000);
        wr(4'h8, 16'h0123);
        wr(4'h9, 16'h0456);
        wr(4'h0, 16'h0083);
        i_cpc_pin_model.send(5);
        rd(4'h0, v);
        chk(v, 16'h009B);
        repeat (4) begin
            rd(4'h1, v);
            chk(v, 16'h0123);
        end
        rd(4'h0, v);
        chk(v, 16'h0093);
        wr(4'h0, 16'h0000);
        wr(4'h0, 16'h0003);
        i_cpc_pin_model.send(1);
        rd(4'h1, v);
        chk(v, 16'h0456);
        wr(4'hA, 16'hFFFF);
        rd(4'hA, v);
        chk(v, 16'h0000);
        $display("test capture fifo done");
        // period before run, rise then fall times, mode before run bit
        wr(4'h8, 16'h0000);
        wr(4'h6, 16'h0014);
        wr(4'h3, 16'h0005);
        wr(4'h4, 16'h0009);
        wr(4'h2, 16'h0204);
        wr(4'h5, 16'h0001);
        win(100, 16'h0001, 16'h0004);
        chk({15'h0000, o_compare_irq}, 16'h0001);
        wr(4'h2, 16'h0304);
        win(100, 16'h0001, 16'h0004);
        wr(4'h2, 16'h0105);
        repeat (25) @(posedge i_ref_clk);
        win(210, 16'h000A, 16'h0028);
        rd(4'h2, v);
        chk(v, 16'h0105);
        wr(4'h2, 16'h000C);
        win(100, 16'h0000, 16'h0000);
        $display("test compare done");
        @(posedge i_ref_clk) i_rst_b <= 1'b0;
        repeat (12) @(posedge i_ref_clk);
        i_rst_b <= 1'b1;
        rd(4'h6, v);
        chk(v, 16'hFFFF);
        rd(4'h2, v);
        chk(v, 16'h0000);
        $display("test reset done");
        give_verdict();
    end
endmodule // tb_capture_and_pulse_compare
